// ===== hdl/pimc_port_cfg.v
`timescale 1ns/10ps
`default_nettype none
`include "pimc_consts.vh"

module pimc_port_cfg #(
   parameter TIMEOUT_CYC = `PIMC_LINK_TIMEOUT_NS / `PIMC_CLK_PERIOD_NS,
   parameter HALF_CYC = `PIMC_LINK_CLK_PERIOD_NS / (2 * `PIMC_CLK_PERIOD_NS)
) (
   input wire clk_in, // System clock, 20 MHz
   input wire reset_n_in, // Synchronous reset, active low
   input wire psel_in, // APB select
   input wire penable_in, // APB enable
   input wire pwrite_in, // APB direction, high for write
   input wire [19:0] paddr_in, // APB byte address
   input wire [31:0] pwdata_in, // APB write data
   input wire [3:0] pstrb_in, // APB write strobes
   output wire [31:0] prdata_out, // APB read data
   output wire pready_out, // APB ready
   output wire pslverr_out, // APB error, unmapped address
   input wire speed_strap_pin_in, // Speed strap pin
   input wire clock_role_strap_pin_in, // Clock role strap pin
   input wire [1:0] interface_type_strap_pins_in, // Type strap pins
   input wire duplex_full_in, // Port in full duplex
   input wire speed_100_in, // Companion speed bit
   input wire switch_fc_filter_in, // Switch-level flow-control filter
   input wire frame_valid_in, // Frame verdict request, pulse
   input wire frame_bad_in, // Frame has CRC or length error
   input wire frame_is_fc_in, // Frame is a flow-control frame
   output wire frame_drop_out, // Verdict: drop, pulse
   output wire frame_mirror_only_out, // Verdict: mirror only, pulse
   output wire frame_forward_out, // Verdict: forward, pulse
   input wire link_rxc_in, // Receive clock pin, input side
   output wire link_rxc_out, // Receive clock pin, output side
   output wire link_rxc_oe_out, // Receive clock pin, output enable
   output wire [1:0] speed_code_out, // Effective speed
   output wire [1:0] iface_code_out, // Effective interface
   output wire clock_drive_out, // Device drives interface clocks
   output wire rx_clock_delay_enable_out, // Ingress clock delay cell on
   output wire tx_clock_delay_enable_out, // Egress clock delay cell on
   output wire storm_protect_en_out, // Broadcast storm protection on
   output wire backpressure_en_out, // Half-duplex back pressure active
   output wire fc_filter_en_out // Flow-control frame filtering on
);

   localparam ST_STRAP = 2'b01;
   localparam ST_RUN = 2'b10;

   reg [1:0] state_q;
   reg [1:0] strap_cnt_q;
   reg [7:0] ifsel_q;
   reg [7:0] storm_q;
   reg [7:0] bppa_q;
   reg [31:0] prdata_q;
   reg pslverr_q;
   reg link_prev_q;
   reg link_active_q;
   reg [15:0] idle_cnt_q;
   reg [7:0] div_cnt_q;
   reg gen_clk_q;
   reg drop_q;
   reg mirror_q;
   reg forward_q;
   reg [1:0] speed_q;
   reg [1:0] iface_q;
   reg drive_q;
   reg rxdly_q;
   reg txdly_q;
   reg storm_en_q;
   reg bp_en_q;
   reg fc_filter_q;

   wire [`PIMC_SYNC_WIDTH-1:0] sync_w;
   wire link_rxc_s;
   wire [1:0] strap_type_s;
   wire strap_speed_s;
   wire strap_role_s;
   wire link_edge;
   wire apb_done;
   wire apb_wr;
   wire hit_ifsel;
   wire hit_storm;
   wire hit_bppa;
   wire hit_status;
   wire hit_any;
   wire [1:0] speed_now;
   wire [1:0] iface_now;
   wire drive_now;
   wire drive_next;
   wire [7:0] status_now;
   wire fc_blocked;

   // Decode one register word by index
   function addr_hit;
      input [19:0] addr;
      input [15:0] idx;
      begin
         addr_hit = (addr == {2'h0, idx, 2'h0});
      end
   endfunction

   // Effective speed from select and companion bits
   function [1:0] speed_decode;
      input sel;
      input s100;
      begin
         speed_decode = !sel ? `PIMC_SPEED_1000 :
            (s100 ? `PIMC_SPEED_100 : `PIMC_SPEED_10);
      end
   endfunction

   // Effective interface from type field and speed select
   function [1:0] iface_decode;
      input [1:0] typ;
      input sel;
      begin
         case (typ)
            `PIMC_TYPE_RGMII: iface_decode = `PIMC_IFACE_RGMII;
            `PIMC_TYPE_RMII: iface_decode = `PIMC_IFACE_RMII;
            `PIMC_TYPE_GMII_MII:
               iface_decode = sel ? `PIMC_IFACE_MII : `PIMC_IFACE_GMII;
            default: iface_decode = `PIMC_IFACE_MII;
         endcase
      end
   endfunction

   // Masked byte write; read-only bits keep their value
   function [7:0] rw_merge;
      input [7:0] old;
      input [7:0] wdat;
      input [7:0] mask;
      begin
         rw_merge = (old & ~mask) | (wdat & mask);
      end
   endfunction

   pimc_sync2 #(
      .WIDTH(`PIMC_SYNC_WIDTH)
   ) u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .async_in({link_rxc_in, clock_role_strap_pin_in,
                 speed_strap_pin_in, interface_type_strap_pins_in}),
      .sync_out(sync_w)
   );

   assign link_rxc_s = sync_w[4];
   assign strap_role_s = sync_w[3];
   assign strap_speed_s = sync_w[2];
   assign strap_type_s = sync_w[1:0];
   assign link_edge = link_rxc_s ^ link_prev_q;
   assign hit_ifsel = addr_hit(paddr_in, `PIMC_IDX_IFSEL);
   assign hit_storm = addr_hit(paddr_in, `PIMC_IDX_STORM);
   assign hit_bppa = addr_hit(paddr_in, `PIMC_IDX_BPPA);
   assign hit_status = addr_hit(paddr_in, `PIMC_IDX_STATUS);
   assign hit_any = hit_ifsel | hit_storm | hit_bppa | hit_status;
   // Hold the bus until straps have been taken
   assign pready_out = (state_q == ST_RUN);
   assign apb_done = psel_in & penable_in & pready_out;
   assign apb_wr = apb_done & pwrite_in & pstrb_in[0] & hit_any;

   assign speed_now = speed_decode(ifsel_q[`PIMC_IF_SPEED_BIT],
                                   speed_100_in);
   assign iface_now = iface_decode(
      ifsel_q[`PIMC_IF_TYPE_HI:`PIMC_IF_TYPE_LO],
      ifsel_q[`PIMC_IF_SPEED_BIT]);
   assign drive_now = ifsel_q[`PIMC_IF_ROLE_BIT] &
                      ((iface_now == `PIMC_IFACE_MII) |
                       (iface_now == `PIMC_IFACE_RMII));
   // Pin enable and divided clock leave drive in the same cycle
   assign drive_next = drive_now & (state_q == ST_RUN);
   assign status_now = {2'h0, drive_now, iface_now, speed_now,
                        link_active_q};
   // filter set by switch control only
   assign fc_blocked = frame_is_fc_in & switch_fc_filter_in;

   // Strap capture after reset release
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_q <= ST_STRAP;
         strap_cnt_q <= 2'h0;
      end else begin
         case (state_q)
            ST_STRAP: begin
               if (strap_cnt_q == `PIMC_STRAP_WAIT) begin
                  state_q <= ST_RUN;
               end else begin
                  strap_cnt_q <= strap_cnt_q + 2'h1;
               end
            end
            ST_RUN: state_q <= ST_RUN;
            default: begin
               state_q <= ST_STRAP;
            end
         endcase
      end
   end

   // Register file
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         ifsel_q <= `PIMC_IF_RESET;
         storm_q <= `PIMC_STORM_RESET;
         bppa_q <= `PIMC_BPPA_RESET;
      end else if (state_q == ST_STRAP) begin
         if (strap_cnt_q == `PIMC_STRAP_WAIT) begin
            ifsel_q[`PIMC_IF_SPEED_BIT] <= strap_speed_s;
            ifsel_q[`PIMC_IF_ROLE_BIT] <= strap_role_s;
            ifsel_q[`PIMC_IF_TYPE_HI:`PIMC_IF_TYPE_LO] <= strap_type_s;
         end
      end else if (apb_wr) begin
         if (hit_ifsel) begin
            ifsel_q <= rw_merge(ifsel_q, pwdata_in[7:0], `PIMC_IF_RW_MASK);
         end
         if (hit_storm) begin
            storm_q <= rw_merge(storm_q, pwdata_in[7:0],
                                `PIMC_STORM_RW_MASK);
         end
         if (hit_bppa) begin
            bppa_q <= rw_merge(bppa_q, pwdata_in[7:0], `PIMC_BPPA_RW_MASK);
         end
      end
   end

   // Read data and error captured before completion
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (psel_in & ~apb_done) begin
         pslverr_q <= ~hit_any;
         if (hit_ifsel) begin
            prdata_q <= {24'h0, ifsel_q};
         end else if (hit_storm) begin
            prdata_q <= {24'h0, storm_q};
         end else if (hit_bppa) begin
            prdata_q <= {24'h0, bppa_q};
         end else if (hit_status) begin
            prdata_q <= {24'h0, status_now};
         end else begin
            prdata_q <= 32'h0;
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pslverr_out = pslverr_q & apb_done;

   // Link clock activity monitor
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         link_prev_q <= 1'b0;
         link_active_q <= 1'b0;
         idle_cnt_q <= 16'h0;
      end else begin
         link_prev_q <= link_rxc_s;
         if (link_edge) begin
            idle_cnt_q <= 16'h0;
            link_active_q <= 1'b1;
         end else if (idle_cnt_q == TIMEOUT_CYC[15:0]) begin
            link_active_q <= 1'b0;
         end else begin
            idle_cnt_q <= idle_cnt_q + 16'h1;
         end
      end
   end

   // Clock generator for PHY or reference-clock-out role
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         div_cnt_q <= 8'h0;
         gen_clk_q <= 1'b0;
      end else if (!drive_next) begin
         div_cnt_q <= 8'h0;
         gen_clk_q <= 1'b0;
      end else if (div_cnt_q == HALF_CYC[7:0] - 8'h1) begin
         div_cnt_q <= 8'h0;
         gen_clk_q <= ~gen_clk_q;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h1;
      end
   end

   assign link_rxc_out = gen_clk_q;
   assign link_rxc_oe_out = drive_q;

   // Frame verdicts, one cycle after the request
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         drop_q <= 1'b0;
         mirror_q <= 1'b0;
         forward_q <= 1'b0;
      end else begin
         drop_q <= frame_valid_in &
                   ((frame_bad_in & ~bppa_q[`PIMC_PASSALL_BIT]) |
                    fc_blocked);
         mirror_q <= frame_valid_in & frame_bad_in &
                     bppa_q[`PIMC_PASSALL_BIT] & ~fc_blocked;
         forward_q <= frame_valid_in & ~frame_bad_in & ~fc_blocked;
      end
   end

   assign frame_drop_out = drop_q;
   assign frame_mirror_only_out = mirror_q;
   assign frame_forward_out = forward_q;

   // Registered configuration outputs
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         speed_q <= `PIMC_SPEED_1000;
         iface_q <= `PIMC_IFACE_RGMII;
         drive_q <= 1'b0;
         rxdly_q <= 1'b0;
         txdly_q <= 1'b0;
         storm_en_q <= 1'b0;
         bp_en_q <= 1'b0;
         fc_filter_q <= 1'b0;
      end else begin
         speed_q <= speed_now;
         iface_q <= iface_now;
         drive_q <= drive_next;
         rxdly_q <= ifsel_q[`PIMC_IF_RXDLY_BIT];
         txdly_q <= ifsel_q[`PIMC_IF_TXDLY_BIT];
         storm_en_q <= storm_q[`PIMC_STORM_BIT];
         bp_en_q <= bppa_q[`PIMC_BP_BIT] & ~duplex_full_in;
         fc_filter_q <= switch_fc_filter_in;
      end
   end

   assign speed_code_out = speed_q;
   assign iface_code_out = iface_q;
   assign clock_drive_out = drive_q;
   assign rx_clock_delay_enable_out = rxdly_q;
   assign tx_clock_delay_enable_out = txdly_q;
   assign storm_protect_en_out = storm_en_q;
   assign backpressure_en_out = bp_en_q;
   assign fc_filter_en_out = fc_filter_q;

endmodule

`default_nettype wire

// ===== shared/pimc_consts.vh
`ifndef PIMC_CONSTS_VH
`define PIMC_CONSTS_VH

// Register indices; byte address is four times the index
`define PIMC_IDX_IFSEL 16'h6301
`define PIMC_IDX_STORM 16'h6400
`define PIMC_IDX_BPPA 16'h6401
`define PIMC_IDX_STATUS 16'h6302

// Interface select register fields
`define PIMC_IF_SPEED_BIT 6
`define PIMC_IF_RXDLY_BIT 4
`define PIMC_IF_TXDLY_BIT 3
`define PIMC_IF_ROLE_BIT 2
`define PIMC_IF_TYPE_HI 1
`define PIMC_IF_TYPE_LO 0
`define PIMC_IF_RW_MASK 8'hff
`define PIMC_IF_RESET 8'h08

// Storm control register fields
`define PIMC_STORM_BIT 1
`define PIMC_STORM_RW_MASK 8'h0b
`define PIMC_STORM_RESET 8'h00

// Back pressure and pass-all register fields
`define PIMC_BP_BIT 3
`define PIMC_PASSALL_BIT 0
`define PIMC_BPPA_RW_MASK 8'hbf
`define PIMC_BPPA_RESET 8'h00

// Status register fields
`define PIMC_ST_ACTIVE_BIT 0
`define PIMC_ST_SPEED_LO 1
`define PIMC_ST_IFACE_LO 3
`define PIMC_ST_DRIVE_BIT 5

// Interface type field codes
`define PIMC_TYPE_RGMII 2'h0
`define PIMC_TYPE_RMII 2'h1
`define PIMC_TYPE_GMII_MII 2'h2
`define PIMC_TYPE_MII 2'h3

// Effective interface codes
`define PIMC_IFACE_RGMII 2'h0
`define PIMC_IFACE_RMII 2'h1
`define PIMC_IFACE_GMII 2'h2
`define PIMC_IFACE_MII 2'h3

// Effective speed codes
`define PIMC_SPEED_10 2'h0
`define PIMC_SPEED_100 2'h1
`define PIMC_SPEED_1000 2'h2

// Timing
`define PIMC_CLK_PERIOD_NS 50
`define PIMC_LINK_CLK_PERIOD_NS 400
`define PIMC_LINK_TIMEOUT_NS 3200
`define PIMC_STRAP_WAIT 2'h3
`define PIMC_SYNC_WIDTH 5

`endif

// ===== hdl/pimc_sync2.v
`timescale 1ns/10ps
`default_nettype none

module pimc_sync2 #(
   parameter WIDTH = 1
) (
   input wire clk_in, // System clock
   input wire reset_n_in, // Synchronous reset, active low
   input wire [WIDTH-1:0] async_in, // Signals from outside the domain
   output wire [WIDTH-1:0] sync_out // Synchronised copy
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // Second stage alone reads the first
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

// ===== bench/pimc_port_cfg_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "pimc_consts.vh"

module pimc_port_cfg_checker (
   input wire logic clk_in, // Clock
   input wire logic reset_n_in, // Reset, active low
   input wire logic duplex_full_in, // Full duplex
   input wire logic switch_fc_filter_in, // Filter enable
   input wire logic frame_valid_in, // Frame request
   input wire logic frame_bad_in, // Bad frame
   input wire logic frame_is_fc_in, // Flow-control frame
   input wire logic frame_drop_out, // Drop
   input wire logic frame_mirror_only_out, // Mirror only
   input wire logic frame_forward_out, // Forward
   input wire logic link_rxc_out, // Driven clock
   input wire logic link_rxc_oe_out, // Pin enable
   input wire logic [1:0] speed_code_out, // Speed
   input wire logic [1:0] iface_code_out, // Interface
   input wire logic clock_drive_out, // Drives clocks
   input wire logic backpressure_en_out, // Back pressure
   input wire logic fc_filter_en_out // Filter copy
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_fc_hit;
      frame_valid_in && frame_is_fc_in && switch_fc_filter_in;
   endsequence
   sequence s_good;
      frame_valid_in && !frame_bad_in &&
         !(frame_is_fc_in && switch_fc_filter_in);
   endsequence
   sequence s_bad;
      frame_valid_in && frame_bad_in &&
         !(frame_is_fc_in && switch_fc_filter_in);
   endsequence
   chk_good_forward: assert property (s_good |=> frame_forward_out)
      else $error("good frame not forwarded");
   chk_bad_held: assert property (s_bad |=> !frame_forward_out)
      else $error("bad frame forwarded");
   chk_fc_drop: assert property (s_fc_hit |=> frame_drop_out)
      else $error("filtered frame not dropped");
   chk_verdict_one: assert property (frame_valid_in |=>
      $onehot({frame_drop_out, frame_mirror_only_out, frame_forward_out}))
      else $error("verdict not one-hot");
   chk_bp_half: assert property (backpressure_en_out |->
      !$past(duplex_full_in))
      else $error("back pressure in full duplex");
   chk_filter_copy: assert property ($past(reset_n_in) |->
      fc_filter_en_out == $past(switch_fc_filter_in))
      else $error("filter enable not followed");
   chk_gmii_gig: assert property (iface_code_out == `PIMC_IFACE_GMII
      |-> speed_code_out == `PIMC_SPEED_1000)
      else $error("gmii below gigabit");
   chk_drive_iface: assert property (link_rxc_oe_out |-> clock_drive_out
      && iface_code_out inside {`PIMC_IFACE_RMII, `PIMC_IFACE_MII})
      else $error("clock driven in wrong mode");
   chk_idle_rxc: assert property (!link_rxc_oe_out |-> !link_rxc_out)
      else $error("clock toggles while released");
endmodule

bind pimc_port_cfg pimc_port_cfg_checker i_pimc_port_cfg_checker (
   .clk_in(clk_in), .reset_n_in(reset_n_in),
   .duplex_full_in(duplex_full_in),
   .switch_fc_filter_in(switch_fc_filter_in),
   .frame_valid_in(frame_valid_in), .frame_bad_in(frame_bad_in),
   .frame_is_fc_in(frame_is_fc_in), .frame_drop_out(frame_drop_out),
   .frame_mirror_only_out(frame_mirror_only_out),
   .frame_forward_out(frame_forward_out), .link_rxc_out(link_rxc_out),
   .link_rxc_oe_out(link_rxc_oe_out), .speed_code_out(speed_code_out),
   .iface_code_out(iface_code_out), .clock_drive_out(clock_drive_out),
   .backpressure_en_out(backpressure_en_out),
   .fc_filter_en_out(fc_filter_en_out));
`default_nettype wire

// ===== bench/pimc_link_peer.sv
`timescale 1ns/10ps
`default_nettype none

module pimc_link_peer (
   input wire logic run_in, // Frame in progress
   input wire logic released_in, // Device drives the pin
   output logic link_clk_out // Clock toward the device
);
   // Free phase; stands still outside frames
   initial begin
      link_clk_out = 1'b0;
      #37;
      forever begin
         #200;
         if (run_in && !released_in)
            link_clk_out = !link_clk_out;
      end
   end
endmodule
`default_nettype wire

// ===== bench/pimc_port_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pimc_consts.vh"

module pimc_port_cfg_tb;
   localparam [19:0] A_IF = {2'h0, `PIMC_IDX_IFSEL, 2'h0};
   localparam [19:0] A_ST = {2'h0, `PIMC_IDX_STORM, 2'h0};
   localparam [19:0] A_BP = {2'h0, `PIMC_IDX_BPPA, 2'h0};
   localparam [19:0] A_SS = {2'h0, `PIMC_IDX_STATUS, 2'h0};
   logic clk_in = 1'b0, reset_n_in = 1'b0, psel = 1'b0, pen = 1'b0;
   logic pwr = 1'b0, sp, rl, dup = 1'b0, s100 = 1'b0, filt = 1'b0;
   logic fv = 1'b0, fb = 1'b0, ffc = 1'b0, run = 1'b0;
   logic [1:0] ty;
   logic [19:0] paddr = 20'h00000;
   logic [31:0] pwd = 32'h00000000;
   wire [31:0] prdata;
   wire [1:0] spd, ifc;
   wire prdy, perr, drop, mir, fwd, rxo, oe, drv, rxd, txd, stp, bpo;
   wire fco, pclk, lnk;
   int failures = 0, checks_done = 0, cyc = 0;

   assign lnk = oe ? rxo : pclk;
   initial forever #25 clk_in = !clk_in;

   pimc_link_peer i_pimc_link_peer (.run_in(run), .released_in(oe),
      .link_clk_out(pclk));
   pimc_port_cfg #(.TIMEOUT_CYC(8), .HALF_CYC(4)) i_pimc_port_cfg (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prdata),
      .pready_out(prdy), .pslverr_out(perr), .speed_strap_pin_in(sp),
      .clock_role_strap_pin_in(rl), .interface_type_strap_pins_in(ty),
      .duplex_full_in(dup), .speed_100_in(s100),
      .switch_fc_filter_in(filt), .frame_valid_in(fv),
      .frame_bad_in(fb), .frame_is_fc_in(ffc), .frame_drop_out(drop),
      .frame_mirror_only_out(mir), .frame_forward_out(fwd),
      .link_rxc_in(lnk), .link_rxc_out(rxo), .link_rxc_oe_out(oe),
      .speed_code_out(spd), .iface_code_out(ifc), .clock_drive_out(drv),
      .rx_clock_delay_enable_out(rxd), .tx_clock_delay_enable_out(txd),
      .storm_protect_en_out(stp), .backpressure_en_out(bpo),
      .fc_filter_en_out(fco));

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         final_report;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [19:0] a,
         input logic [7:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= {24'h000000, d};
      @(posedge clk_in);
      pen <= 1'b1;
      @(posedge clk_in);
      while (prdy !== 1'b1)
         @(posedge clk_in);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdc(input logic [19:0] a, input logic [31:0] x,
         input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   function automatic logic [1:0] f_spd(input logic [7:0] b);
      if (!b[6])
         return `PIMC_SPEED_1000;
      return s100 ? `PIMC_SPEED_100 : `PIMC_SPEED_10;
   endfunction

   function automatic logic [1:0] f_ifc(input logic [7:0] b);
      case (b[1:0])
         `PIMC_TYPE_RGMII: return `PIMC_IFACE_RGMII;
         `PIMC_TYPE_RMII: return `PIMC_IFACE_RMII;
         `PIMC_TYPE_MII: return `PIMC_IFACE_MII;
         default: return b[6] ? `PIMC_IFACE_MII : `PIMC_IFACE_GMII;
      endcase
   endfunction

   function automatic logic f_drv(input logic [7:0] b);
      return b[2] && f_ifc(b) inside {`PIMC_IFACE_RMII, `PIMC_IFACE_MII};
   endfunction

   task automatic cfg(input logic [7:0] b);
      repeat (2) @(posedge clk_in);
      chk({30'h0, spd}, {30'h0, f_spd(b)});
      chk({30'h0, ifc}, {30'h0, f_ifc(b)});
      chk({29'h0, drv, rxd, txd}, {29'h0, f_drv(b), b[4], b[3]});
   endtask

   task automatic frame(input logic pa);
      logic bd, fc, fl;
      logic hit;
      {bd, fc, fl} = 3'($urandom);
      hit = fc & fl;
      @(posedge clk_in);
      fv <= 1'b1;
      fb <= bd;
      ffc <= fc;
      filt <= fl;
      @(posedge clk_in);
      fv <= 1'b0;
      @(posedge clk_in);
      chk({29'h0, drop, mir, fwd}, {29'h0, hit | bd & !pa,
         bd & pa & !hit, !bd & !hit});
      chk({31'h0, fco}, {31'h0, fl});
   endtask

   initial begin
      logic [7:0] b;
      int i, j;
      void'($urandom(73));
      {sp, rl, ty} <= 4'($urandom);
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      b = {1'b0, sp, 3'b001, rl, ty};
      rdc(A_IF, {24'h0, b}, 1'b0);
      rdc(A_ST, 32'h0, 1'b0);
      rdc(A_BP, 32'h0, 1'b0);
      cfg(b);
      $display("test reset done");
      for (i = 0; i < 32; i++) begin
         b = 8'($urandom);
         b[6] = i[2];
         b[2] = i[3];
         b[1:0] = i[1:0];
         s100 <= b[7];
         wr(A_IF, b);
         rdc(A_IF, {24'h0, b}, 1'b0);
         cfg(b);
      end
      $display("test interface done");
      for (i = 0; i < 2; i++) begin
         b = i[0] ? 8'h00 : 8'hff;
         wr(A_ST, b);
         rdc(A_ST, {24'h0, b & 8'h0b}, 1'b0);
         chk({31'h0, stp}, {31'h0, b[1]});
      end
      rdc(20'h00010, 32'h0, 1'b1);
      $display("test storm done");
      for (i = 0; i < 4; i++) begin
         b = 8'($urandom);
         b[3] = i[1];
         b[0] = i[0];
         b[7] = i[0];
         dup <= b[7];
         wr(A_BP, b);
         rdc(A_BP, {24'h0, b & 8'hbf}, 1'b0);
         chk({31'h0, bpo}, {31'h0, b[3] & !b[7]});
         for (j = 0; j < 12; j++)
            frame(b[0]);
      end
      $display("test frames done");
      s100 <= 1'b1;
      wr(A_IF, 8'h08);
      run <= 1'b1;
      repeat (100) @(posedge clk_in);
      rdc(A_SS, 32'h05, 1'b0);
      run <= 1'b0;
      repeat (30) @(posedge clk_in);
      rdc(A_SS, 32'h04, 1'b0);
      wr(A_IF, 8'h47);
      repeat (30) @(posedge clk_in);
      rdc(A_SS, 32'h3b, 1'b0);
      $display("test link clock done");
      final_report;
   end
endmodule
`default_nettype wire
